// ===== logic/aew_fetch_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Notes on behaviour
// - Vertical window start from bits 27:16
// - Horizontal window start from bits 11:0
// - Black row: own start, shares horizontal
// - Black height is (code+1)*2
// - Vertical sample step is (code+1)*2
// - Horizontal sample step is (code+1)*2
// - Stats base drops low six bits
// - Address writes apply next frame only
// - Read base drops low five bits
// - Line stride drops low five bits
// - Three-bit code selects ten-bit window
// - Lines per frame from bits 27:16
// - Pixels per line from bits 11:0
// ----------------------------------------------------------------
module aew_fetch_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_busy,
  output logic             o_mem_req,
  output logic      [31:0] o_mem_addr,
  input  wire logic        i_mem_ack,
  input  wire logic        i_mem_vld,
  input  wire logic [15:0] i_mem_word,
  output logic      [9:0]  o_pix,
  output logic             o_pix_vld,
  output logic      [11:0] o_win_v_start,
  output logic      [11:0] o_win_h_start,
  output logic      [11:0] o_black_v_start,
  output logic      [8:0]  o_black_height,
  output logic      [5:0]  o_v_step,
  output logic      [5:0]  o_h_step,
  output logic      [31:0] o_stats_base
);

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  logic [31:0] win_start_ff;
  logic [31:0] black_row_ff;
  logic [31:0] subsample_ff;
  logic [31:0] stats_base_ff;
  logic [31:0] read_base_ff;
  logic [31:0] stride_ff;
  logic [31:0] frame_size_ff;
  logic        go_ff;

  // Shadows latched at frame start
  logic [31:0] act_stats_ff;
  logic [31:0] act_read_ff;
  logic [15:0] act_stride_ff;
  logic [11:0] act_lines_ff;
  logic [11:0] act_pix_ff;
  logic [2:0]  act_sel_ff;

  // Fetch engine state
  aew_pkg::aew_state_t state_ff;
  aew_pkg::aew_state_t nxt_state;
  logic [11:0] line_idx_ff;
  logic [11:0] pix_cnt_ff;
  logic [31:0] line_addr_ff;
  logic [31:0] rdata_ff;
  logic        frame_done_ff;

  logic        start_frame;

  // Field step: (code + 1) * 2, used for all spacing fields
  function automatic logic [8:0] dbl_plus_one(input logic [6:0] code);
    dbl_plus_one = {1'b0, code, 1'b0} + 9'h002;
  endfunction : dbl_plus_one

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // masked writes; stats base and read base are stored unmasked
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      win_start_ff  <= aew_pkg::RST_WORD;
      black_row_ff  <= aew_pkg::RST_WORD;
      subsample_ff  <= aew_pkg::RST_WORD;
      stats_base_ff <= aew_pkg::RST_WORD;
      read_base_ff  <= aew_pkg::RST_WORD;
      stride_ff     <= aew_pkg::RST_WORD;
      frame_size_ff <= aew_pkg::RST_WORD;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        aew_pkg::IDX_WIN_START:  win_start_ff  <= i_wdata & aew_pkg::MASK_WIN_START;
        aew_pkg::IDX_BLACK_ROW:  black_row_ff  <= i_wdata & aew_pkg::MASK_BLACK_ROW;
        aew_pkg::IDX_SUBSAMPLE:  subsample_ff  <= i_wdata & aew_pkg::MASK_SUBSAMPLE;
        aew_pkg::IDX_STATS_BASE: stats_base_ff <= i_wdata;
        aew_pkg::IDX_READ_BASE:  read_base_ff  <= i_wdata;
        aew_pkg::IDX_STRIDE:     stride_ff     <= i_wdata & aew_pkg::MASK_STRIDE;
        aew_pkg::IDX_FRAME_SIZE: frame_size_ff <= i_wdata & aew_pkg::MASK_FRAME_SIZE;
        default: ;
      endcase
    end
  end

  // Start pulse; a start while busy is dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      go_ff <= 1'b0;
    end else if (i_ce) begin
      go_ff <= i_wr && (i_addr == aew_pkg::IDX_CONTROL) && i_wdata[aew_pkg::CTRL_GO];
    end
  end

  assign start_frame = go_ff && (state_ff == aew_pkg::AEW_IDLE);

  // ----------------------------------------------------------------
  // Read back, one cycle latency
  // ----------------------------------------------------------------
  // latest value readback
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rdata_ff <= aew_pkg::RST_WORD;
    end else if (i_ce) begin
      rdata_ff <= 32'h00000000;
      if (i_rd) begin
        unique case (i_addr)
          aew_pkg::IDX_WIN_START:  rdata_ff <= win_start_ff;
          aew_pkg::IDX_BLACK_ROW:  rdata_ff <= black_row_ff;
          aew_pkg::IDX_SUBSAMPLE:  rdata_ff <= subsample_ff;
          aew_pkg::IDX_STATS_BASE: rdata_ff <= stats_base_ff;
          aew_pkg::IDX_READ_BASE:  rdata_ff <= read_base_ff;
          aew_pkg::IDX_STRIDE:     rdata_ff <= stride_ff;
          aew_pkg::IDX_FRAME_SIZE: rdata_ff <= frame_size_ff;
          aew_pkg::IDX_STATUS:     rdata_ff <= {20'h00000, line_idx_ff} | 
                                               {30'h0, frame_done_ff, o_busy} << 30;
          default:                 rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  assign o_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Frame shadows, taken only at frame start
  // ----------------------------------------------------------------
  // shadow at frame
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      act_stats_ff  <= aew_pkg::RST_WORD;
      act_read_ff   <= aew_pkg::RST_WORD;
      act_stride_ff <= 16'h0000;
      act_lines_ff  <= 12'h000;
      act_pix_ff    <= 12'h000;
      act_sel_ff    <= 3'h0;
    end else if (i_ce && start_frame) begin
      act_stats_ff  <= stats_base_ff & aew_pkg::MASK_STATS_ALN;
      act_read_ff   <= read_base_ff & aew_pkg::MASK_READ_ALN;
      act_stride_ff <= stride_ff[15:0] & aew_pkg::MASK_STRIDE_ALN;
      act_lines_ff  <= frame_size_ff[aew_pkg::VERT_MSB:aew_pkg::VERT_LSB];
      act_pix_ff    <= frame_size_ff[aew_pkg::HORZ_MSB:aew_pkg::HORZ_LSB];
      act_sel_ff    <= frame_size_ff[aew_pkg::BSEL_MSB:aew_pkg::BSEL_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      aew_pkg::AEW_IDLE: begin
        if (start_frame) begin
          nxt_state = aew_pkg::AEW_LINE;
        end
      end
      aew_pkg::AEW_LINE: begin
        if (line_idx_ff >= act_lines_ff) begin
          nxt_state = aew_pkg::AEW_IDLE;
        end else if (i_mem_ack) begin
          nxt_state = aew_pkg::AEW_PIX;
        end
      end
      aew_pkg::AEW_PIX: begin
        if (act_pix_ff == 12'h000) begin
          nxt_state = aew_pkg::AEW_LINE;
        end else if (i_mem_vld && (pix_cnt_ff + 12'h001 >= act_pix_ff)) begin
          nxt_state = aew_pkg::AEW_LINE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_ff <= aew_pkg::AEW_IDLE;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // Line index and address walk
  // base plus stride
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      line_idx_ff  <= 12'h000;
      line_addr_ff <= aew_pkg::RST_WORD;
    end else if (i_ce) begin
      if (start_frame) begin
        line_idx_ff  <= 12'h000;
        line_addr_ff <= read_base_ff & aew_pkg::MASK_READ_ALN;
      end else if (state_ff == aew_pkg::AEW_PIX && nxt_state == aew_pkg::AEW_LINE) begin
        line_idx_ff  <= line_idx_ff + 12'h001;
        line_addr_ff <= line_addr_ff + {16'h0000, act_stride_ff};
      end
    end
  end

  // Pixel count within the line; zero-width lines end at once
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pix_cnt_ff <= 12'h000;
    end else if (i_ce) begin
      if (state_ff != aew_pkg::AEW_PIX) begin
        pix_cnt_ff <= 12'h000;
      end else if (i_mem_vld) begin
        pix_cnt_ff <= pix_cnt_ff + 12'h001;
      end
    end
  end

  // Done flag, cleared by the next start
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      frame_done_ff <= 1'b0;
    end else if (i_ce) begin
      if (state_ff == aew_pkg::AEW_LINE && nxt_state == aew_pkg::AEW_IDLE) begin
        frame_done_ff <= 1'b1;
      end else if (start_frame) begin
        frame_done_ff <= 1'b0;
      end
    end
  end

  assign o_busy     = (state_ff != aew_pkg::AEW_IDLE);
  assign o_mem_req  = (state_ff == aew_pkg::AEW_LINE) && (line_idx_ff < act_lines_ff);
  assign o_mem_addr = line_addr_ff;

  // ----------------------------------------------------------------
  // Pixel extraction
  // ----------------------------------------------------------------
  aew_bit_window_select u_bit_window_select (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_vld     (i_mem_vld && (state_ff == aew_pkg::AEW_PIX) && (act_pix_ff != 12'h000)),
    .i_sel     (act_sel_ff),
    .i_word    (i_mem_word),
    .o_pix     (o_pix),
    .o_vld     (o_pix_vld)
  );

  // ----------------------------------------------------------------
  // Window geometry towards the statistics core
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_win_v_start   <= 12'h000;
      o_win_h_start   <= 12'h000;
      o_black_v_start <= 12'h000;
      o_black_height  <= 9'h000;
      o_v_step        <= 6'h00;
      o_h_step        <= 6'h00;
      o_stats_base    <= aew_pkg::RST_WORD;
    end else if (i_ce) begin
      o_win_v_start   <= win_start_ff[aew_pkg::VERT_MSB:aew_pkg::VERT_LSB];
      o_win_h_start   <= win_start_ff[aew_pkg::HORZ_MSB:aew_pkg::HORZ_LSB];
      o_black_v_start <= black_row_ff[aew_pkg::VERT_MSB:aew_pkg::VERT_LSB];
      o_black_height  <= dbl_plus_one(black_row_ff[aew_pkg::HGT_MSB:0]);
      o_v_step        <= 6'(dbl_plus_one({3'h0,
                           subsample_ff[aew_pkg::VINC_MSB:aew_pkg::VINC_LSB]}));
      o_h_step        <= 6'(dbl_plus_one({3'h0, subsample_ff[aew_pkg::HINC_MSB:0]}));
      o_stats_base    <= act_stats_ff;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_read_align;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_mem_req |-> (o_mem_addr[4:0] == 5'h00);
  endproperty
  a_read_align: assert property (p_read_align) else $error("fetch address misaligned");

  property p_stats_align;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_stats_base[5:0] == 6'h00;
  endproperty
  a_stats_align: assert property (p_stats_align) else $error("stats base misaligned");

  property p_next_line;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && state_ff == aew_pkg::AEW_PIX && nxt_state == aew_pkg::AEW_LINE)
      |=> (o_mem_addr == $past(o_mem_addr) + {16'h0000, act_stride_ff});
  endproperty
  a_next_line: assert property (p_next_line) else $error("line step wrong");

  property p_shadow_hold;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (o_busy && $past(o_busy)) |-> $stable(act_read_ff);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved mid frame");

  property p_line_limit;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_busy |-> (line_idx_ff <= act_lines_ff);
  endproperty
  a_line_limit: assert property (p_line_limit) else $error("too many lines");

  property p_pix_limit;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (state_ff == aew_pkg::AEW_PIX) |-> (pix_cnt_ff < act_pix_ff || act_pix_ff == 12'h000);
  endproperty
  a_pix_limit: assert property (p_pix_limit) else $error("too many pixels");

  property p_step_even;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      $past(i_ce) |-> (o_h_step[0] == 1'b0 && o_v_step[0] == 1'b0 &&
                       o_black_height[0] == 1'b0);
  endproperty
  a_step_even: assert property (p_step_even) else $error("odd step");

  property p_rsvd_zero;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ce && i_rd && i_addr == aew_pkg::IDX_SUBSAMPLE) |=> (o_rdata[31:12] == 20'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

endmodule : aew_fetch_top
`default_nettype wire

// ===== logic/aew_pkg.sv
package aew_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_WIN_START  = 4'h0;
  localparam logic [3:0] IDX_BLACK_ROW  = 4'h1;
  localparam logic [3:0] IDX_SUBSAMPLE  = 4'h2;
  localparam logic [3:0] IDX_STATS_BASE = 4'h3;
  localparam logic [3:0] IDX_READ_BASE  = 4'h4;
  localparam logic [3:0] IDX_STRIDE     = 4'h5;
  localparam logic [3:0] IDX_FRAME_SIZE = 4'h6;
  localparam logic [3:0] IDX_CONTROL    = 4'h7;
  localparam logic [3:0] IDX_STATUS     = 4'h8;

  // ----------------------------------------------------------------
  // Writable field masks (reserved bits read zero), then alignment masks
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_WIN_START  = 32'h0fff0fff;
  localparam logic [31:0] MASK_BLACK_ROW  = 32'h0fff007f;
  localparam logic [31:0] MASK_SUBSAMPLE  = 32'h00000f0f;
  localparam logic [31:0] MASK_STRIDE     = 32'h0000ffff;
  localparam logic [31:0] MASK_FRAME_SIZE = 32'h7fff0fff;
  localparam logic [31:0] MASK_STATS_ALN  = 32'hffffffc0;
  localparam logic [31:0] MASK_READ_ALN   = 32'hffffffe0;
  localparam logic [15:0] MASK_STRIDE_ALN = 16'hffe0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VERT_LSB  = 16;
  localparam int VERT_MSB  = 27;
  localparam int HORZ_LSB  = 0;
  localparam int HORZ_MSB  = 11;
  localparam int HGT_MSB   = 6;
  localparam int VINC_LSB  = 8;
  localparam int VINC_MSB  = 11;
  localparam int HINC_MSB  = 3;
  localparam int BSEL_LSB  = 28;
  localparam int BSEL_MSB  = 30;
  localparam int CTRL_GO   = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD      = 32'h00000000;
  localparam logic [2:0]  BSEL_RESERVED = 3'h7;
  localparam logic [3:0]  NUM_REGS      = 4'h9;

  typedef enum logic [1:0] {AEW_IDLE, AEW_LINE, AEW_PIX} aew_state_t;

endpackage : aew_pkg

// ===== logic/aew_bit_window_select.sv
`timescale 1ns/1ps
`default_nettype none
// Picks ten bits from a fetched 16-bit word, registered output
module aew_bit_window_select (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  input  wire logic        i_vld,
  input  wire logic [2:0]  i_sel,
  input  wire logic [15:0] i_word,
  output logic      [9:0]  o_pix,
  output logic             o_vld
);

  // ----------------------------------------------------------------
  // Shifted window select
  // ----------------------------------------------------------------
  // shifted bit window
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pix <= 10'h000;
      o_vld <= 1'b0;
    end else if (i_ce) begin
      o_vld <= i_vld && (i_sel != aew_pkg::BSEL_RESERVED);
      if (i_vld && (i_sel != aew_pkg::BSEL_RESERVED)) begin
        o_pix <= 10'((i_word >> i_sel));
      end
    end
  end

endmodule : aew_bit_window_select
`default_nettype wire

// ===== dv/aew_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// Far-side memory: grants line requests, then streams words
// -------------------------------------------------------------
module aew_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_slow,
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic [11:0] i_words,
  output logic             o_ack,
  output logic             o_vld,
  output logic      [15:0] o_word
);
  logic        run_ff;
  logic [11:0] cnt_ff;
  logic [1:0]  gap_ff;
  logic [15:0] seed_ff;

  // Idle word lines toggle, so a stale sample never matches by luck
  always_ff @(posedge i_clk) begin
    o_ack  <= 1'b0;
    o_vld  <= 1'b0;
    o_word <= ~o_word;
    if (i_rst) begin
      run_ff <= 1'b0;
      gap_ff <= 2'h0;
      o_word <= 16'h0000;
    end else if (gap_ff != 2'h0) begin
      gap_ff <= gap_ff - 2'h1;
    end else if (!run_ff && i_req && !o_ack) begin
      o_ack   <= 1'b1;
      run_ff  <= 1'b1;
      cnt_ff  <= 12'h000;
      seed_ff <= i_addr[20:5];
      gap_ff  <= {i_slow, 1'b0};
    end else if (run_ff) begin
      // Slow mode leaves holes between words and between lines
      o_vld  <= 1'b1;
      o_word <= {cnt_ff[3:0], seed_ff[11:0]} ^ 16'h5a3c;
      cnt_ff <= cnt_ff + 12'h001;
      gap_ff <= {1'b0, i_slow};
      if (cnt_ff == i_words - 12'h001) begin
        run_ff <= 1'b0;
        gap_ff <= {i_slow, i_slow};
      end
    end
  end
endmodule : aew_mem_model
`default_nettype wire

// ===== dv/aewb_window_and_frame_fetch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module aewb_window_and_frame_fetch_tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_ce      = 1'b1;
  logic [3:0]  i_addr    = 4'h0;
  logic [31:0] i_wdata   = 32'h0;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        slow      = 1'b0;
  logic [31:0] o_rdata, o_mem_addr, o_stats_base;
  logic        o_busy, o_mem_req, i_mem_ack, i_mem_vld, o_pix_vld;
  logic [15:0] i_mem_word, p_stride;
  logic [9:0]  o_pix, exp_d;
  logic [11:0] o_win_v_start, o_win_h_start, o_black_v_start, p_vs, p_hs, e_vs, e_hs;
  logic [8:0]  o_black_height;
  logic [5:0]  o_v_step, o_h_step;
  logic [31:0] p_base, e_base, e_stride, line_idx, pix_cnt;
  logic [2:0]  p_sel, e_sel;
  logic        vld_d;
  int          miscompares = 0;
  int          check_count = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  aew_fetch_top i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_busy(o_busy), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
    .i_mem_ack(i_mem_ack), .i_mem_vld(i_mem_vld), .i_mem_word(i_mem_word),
    .o_pix(o_pix), .o_pix_vld(o_pix_vld), .o_win_v_start(o_win_v_start),
    .o_win_h_start(o_win_h_start), .o_black_v_start(o_black_v_start),
    .o_black_height(o_black_height), .o_v_step(o_v_step), .o_h_step(o_h_step),
    .o_stats_base(o_stats_base));

  aew_mem_model i_mem (.i_clk(i_ref_clk), .i_rst(i_sys_rst), .i_slow(slow),
    .i_req(o_mem_req), .i_addr(o_mem_addr), .i_words(e_hs), .o_ack(i_mem_ack),
    .o_vld(i_mem_vld), .o_word(i_mem_word));

  // -------------------------------------------------------------
  // Shared checks and bus cycles
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= idx;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string what);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= idx;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, what);
  endtask : rd

  // Pixel and line address monitor, independent of the design's own math
  always @(posedge i_ref_clk) begin
    if (vld_d === 1'b1 || o_pix_vld !== 1'b0) begin
      chk(32'(o_pix_vld), 32'(vld_d && e_sel != 3'h7), "pixel strobe");
      if (vld_d && e_sel != 3'h7) chk(32'(o_pix), 32'(exp_d), "pixel bits");
    end
    if (o_pix_vld === 1'b1) pix_cnt++;
    if (o_mem_req === 1'b1 && i_mem_ack === 1'b1) begin
      chk(o_mem_addr, e_base + line_idx * e_stride, "line address");
      line_idx++;
    end
    vld_d = i_mem_vld;
    exp_d = 10'(i_mem_word >> e_sel);
  end

  // -------------------------------------------------------------
  // Frame helpers
  // -------------------------------------------------------------
  task automatic setup(input logic [31:0] b, input logic [15:0] s, input logic [11:0] v,
                       input logic [11:0] h, input logic [2:0] sel);
    p_base   = b;
    p_stride = s;
    p_vs     = v;
    p_hs     = h;
    p_sel    = sel;
    wr(4'h4, b);
    wr(4'h5, {16'h0, s});
    wr(4'h6, {1'b0, sel, v, 4'h0, h});
  endtask : setup

  // Expectations are frozen at start, as the fetch shadows are
  task automatic go();
    e_base   = p_base & 32'hffff_ffe0;
    e_stride = {16'h0, p_stride & 16'hffe0};
    e_vs     = p_vs;
    e_hs     = p_hs;
    e_sel    = p_sel;
    line_idx = 32'h0;
    pix_cnt  = 32'h0;
    wr(4'h7, 32'h0000_0001);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(32'(o_busy), 32'h1, "busy after start");
  endtask : go

  task automatic finish();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 4000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    repeat (2) @(posedge i_ref_clk);
    chk(32'(o_busy), 32'h0, "frame end");
    chk(line_idx, 32'(e_vs), "lines fetched");
    chk(pix_cnt, (e_sel == 3'h7) ? 32'h0 : 32'(e_vs) * 32'(e_hs), "pixels");
    rd(4'h8, {2'b10, 18'h0, e_vs}, "status");
  endtask : finish

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic test_regs();
    wr(4'h0, 32'hf123_f456);
    wr(4'h1, 32'hfabc_ff85);
    wr(4'h2, 32'hffff_f3fa);
    rd(4'h0, 32'h0123_0456, "window start");
    rd(4'h1, 32'h0abc_0005, "black row");
    rd(4'h2, 32'h0000_030a, "subsample");
    chk(32'(o_win_v_start), 32'h123, "vertical start");
    chk(32'(o_win_h_start), 32'h456, "horizontal start");
    chk(32'(o_black_v_start), 32'habc, "black start");
    chk(32'(o_black_height), 32'h00c, "black height");
    chk(32'(o_v_step), 32'h08, "vertical step");
    chk(32'(o_h_step), 32'h16, "horizontal step");
    wr(4'h1, 32'h0000_007f);
    wr(4'h2, 32'h0000_0f00);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(32'(o_black_height), 32'h100, "black height max");
    chk(32'(o_v_step), 32'h20, "vertical step max");
    chk(32'(o_h_step), 32'h02, "horizontal step min");
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0, "unmapped");
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    wr(4'h0, 32'h0000_0001);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    rd(4'h0, 32'h0123_0456, "write with enable low");
    $display("test registers finished");
  endtask : test_regs

  task automatic test_frame();
    setup(32'h1000_003f, 16'h0047, 12'h003, 12'h004, 3'h2);
    go();
    finish();
    $display("test frame finished");
  endtask : test_frame

  // Address writes land while busy, take effect one frame later
  task automatic test_shadow();
    wr(4'h3, 32'h0000_1000);
    slow <= 1'b1;
    setup(32'h2000_0000, 16'h0100, 12'h003, 12'h005, 3'h0);
    go();
    chk(o_stats_base, 32'h0000_1000, "stats base");
    wr(4'h3, 32'h0000_2fff);
    setup(32'h3000_0000, 16'h0080, 12'h002, 12'h003, 3'h1);
    rd(4'h4, 32'h3000_0000, "read base readback");
    rd(4'h5, 32'h0000_0080, "stride readback");
    chk(o_stats_base, 32'h0000_1000, "stats base held");
    // A start while busy must not restart the line walk
    wr(4'h7, 32'h0000_0001);
    finish();
    go();
    chk(o_stats_base, 32'h0000_2fc0, "stats base next frame");
    finish();
    slow <= 1'b0;
    $display("test shadow finished");
  endtask : test_shadow

  task automatic test_bit_window_select();
    for (int s = 0; s < 8; s++) begin
      setup(32'h0040_0000 + 32'(s) * 32'h0000_1000, 16'h0020, 12'h001, 12'h003, 3'(s));
      go();
      finish();
    end
    $display("test bit select finished");
  endtask : test_bit_window_select

  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd(4'h0, 32'h0, "reset window start");
    rd(4'h1, 32'h0, "reset black row");
    rd(4'h3, 32'h0, "reset stats base");
    rd(4'h4, 32'h0, "reset read base");
    rd(4'h6, 32'h0, "reset frame size");
    chk(32'(o_v_step), 32'h02, "reset vertical step");
    chk(32'(o_h_step), 32'h02, "reset horizontal step");
    chk(32'(o_black_height), 32'h002, "reset black height");
    test_regs();
    test_frame();
    test_shadow();
    test_bit_window_select();
    print_verdict();
  end

  // Whole run is a few hundred cycles; this allows ample slack
  initial begin
    #500us;
    miscompares++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : aewb_window_and_frame_fetch_tb_top
`default_nettype wire
